// ---- design/dvtrg_regs.svh ----
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the trigger block and the bench only
`ifndef DVTRG_REGS_SVH
`define DVTRG_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DVTRG_OFF_MODE 12'h000
`define DVTRG_OFF_DSRC 12'h004
`define DVTRG_OFF_DELAY 12'h008
`define DVTRG_OFF_VCFG 12'h00C
`define DVTRG_OFF_VLINE 12'h010
`define DVTRG_OFF_HOLD 12'h014
`define DVTRG_OFF_STATUS 12'h018
`define DVTRG_OFF_VARIANT 12'h01C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DVTRG_MODE_LSB 0
`define DVTRG_SRC_KIND_LSB 0
`define DVTRG_SRC_IDX_LSB 4
`define DVTRG_SLOPE_BIT 8
`define DVTRG_ARM_KIND_LSB 16
`define DVTRG_ARM_IDX_LSB 20
`define DVTRG_ARM_SLOPE_BIT 24
`define DVTRG_VSRC_LSB 0
`define DVTRG_VPOL_BIT 4
`define DVTRG_VFIELD_BIT 5

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define DVTRG_DELAY_RST 32'h0000_0001
`define DVTRG_VLINE_RST 32'h0000_0001
`define DVTRG_HOLD_RST 32'h0000_0000
`define DVTRG_CLK_PERIOD_PS 25000
`define DVTRG_DELAY_MIN_PS 5000
`define DVTRG_DELAY_MAX_S 10
`define DVTRG_CLK_HZ 40000000
`define DVTRG_DELAY_MIN_CYC ((`DVTRG_DELAY_MIN_PS + `DVTRG_CLK_PERIOD_PS - 1) / `DVTRG_CLK_PERIOD_PS)
`define DVTRG_DELAY_MAX_CYC (`DVTRG_DELAY_MAX_S * `DVTRG_CLK_HZ)

`endif

// ---- design/dvtrg_pkg.sv ----
// Types shared by the trigger block
// Assumes the register header is compiled alongside
package dvtrg_pkg;
  typedef enum logic [1:0] {
    DVTRG_SRC_ANALOG = 2'b00,
    DVTRG_SRC_DIGITAL = 2'b01,
    DVTRG_SRC_EXTERNAL = 2'b10
  } dvtrg_src_t;
  typedef enum logic [1:0] {
    DVTRG_MODE_OFF = 2'b00,
    DVTRG_MODE_DELAY_BY_TIME = 2'b01,
    DVTRG_MODE_VIDEO_525 = 2'b10,
    DVTRG_MODE_VIDEO_625 = 2'b11
  } dvtrg_mode_t;
  typedef enum logic [1:0] {
    DVTRG_ST_IDLE = 2'b00,
    DVTRG_ST_ARMED = 2'b01,
    DVTRG_ST_DELAY = 2'b10,
    DVTRG_ST_LOOK = 2'b11
  } dvtrg_state_t;
endpackage : dvtrg_pkg

// ---- design/dvtrg_edge.sv ----
// Source select and edge detector for one trigger input
// Assumes inputs already synchronised to aclk
`timescale 1ns/10ps
`default_nettype none
module dvtrg_edge #(
  parameter int NUM_ANALOG = 4,
  parameter int NUM_DIGITAL = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Inputs
  input wire logic [NUM_ANALOG-1:0] analog_in,
  input wire logic [NUM_DIGITAL-1:0] digital_in,
  input wire logic external_in,
  // Selection
  input wire logic [1:0] kind,
  input wire logic [3:0] index,
  input wire logic rising,
  // Result
  output logic edge_seen
);
  logic level;
  logic prev_reg;

  always_comb begin
    case (kind)
      2'b00: level = analog_in[index[1:0]];
      2'b01: level = digital_in[index];
      2'b10: level = external_in;
      default: level = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level;
    end
  end

  // Prev and current compared once per cycle
  assign edge_seen = rising ? (level && !prev_reg) : (!level && prev_reg);
endmodule : dvtrg_edge
`default_nettype wire

// ---- design/dvtrg_top.sv ----
// Delayed and video trigger qualifier with AXI4-Lite registers
// Assumes channel comparators outside; inputs asynchronous to aclk
// Behaviour
// - Delay accepted only from 5 ns up to 10 s.
// - After arming, wait delay, then fire on next selected edge.
// - Trigger source may be analog, digital or external input.
// - Analog index 1-2 on two-channel variant, else 1-4.
// - Sixteen digital sources 0-15, only on mixed-signal variants.
// - External source allowed only on two-channel variant.
// - Trigger fires on rising or falling edge per slope setting.
// - Reads return source, slope and delay unchanged.
// - Video trigger takes one selectable channel through threshold comparator.
// - Video sync polarity selectable positive or negative.
// - Video trigger qualified to field one or field two.
// - Triggers on programmed line counted from field vertical sync.
// - Video path supports hold-off and noise rejection conditioning.
// - Arm on selected edge first, only then start delay timing.
// - Line numbers 1 to 625, subrange per field and standard.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "dvtrg_regs.svh"
module dvtrg_top #(
  parameter int NUM_DIGITAL = 16,
  parameter logic [31:0] DELAY_MAX_CYC = 32'(`DVTRG_DELAY_MAX_CYC),
  parameter logic [31:0] VARIANT_ID = 32'h0000_0000
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Variant straps
  input wire logic two_channel,
  input wire logic has_digital,
  // Comparator inputs
  input wire logic [3:0] analog_cmp,
  input wire logic [NUM_DIGITAL-1:0] digital_in,
  input wire logic external_cmp,
  // Video sync separator inputs
  input wire logic vsync_in,
  input wire logic hsync_in,
  input wire logic field_odd_in,
  // Trigger result
  output logic trigger_out
);
  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [NUM_DIGITAL+9:0] sync1_reg;
  logic [NUM_DIGITAL+9:0] sync2_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {two_channel, has_digital, field_odd_in, hsync_in, vsync_in, external_cmp, digital_in, analog_cmp};
      sync2_reg <= sync1_reg;
    end
  end
  logic [3:0] an_s;
  logic [NUM_DIGITAL-1:0] dig_s;
  logic ext_s, vs_s, hs_s, fo_s, hasdig_s, twoch_s;
  assign an_s = sync2_reg[3:0];
  assign dig_s = sync2_reg[NUM_DIGITAL+3:4];
  assign ext_s = sync2_reg[NUM_DIGITAL+4];
  assign vs_s = sync2_reg[NUM_DIGITAL+5];
  assign hs_s = sync2_reg[NUM_DIGITAL+6];
  assign fo_s = sync2_reg[NUM_DIGITAL+7];
  assign hasdig_s = sync2_reg[NUM_DIGITAL+8];
  assign twoch_s = sync2_reg[NUM_DIGITAL+9];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  dvtrg_pkg::dvtrg_mode_t mode_reg;
  logic [31:0] dsrc_reg;
  logic [31:0] delay_reg;
  logic [5:0] vcfg_reg;
  logic [9:0] vline_reg;
  logic [31:0] hold_reg;
  logic reject_reg;

  // Source legality per variant
  function automatic logic src_ok(input logic [1:0] kind, input logic [3:0] idx, input logic two,
                                  input logic dig);
    case (kind)
      2'b00: src_ok = two ? (idx >= 4'h1 && idx <= 4'h2) : (idx >= 4'h1 && idx <= 4'h4);
      2'b01: src_ok = dig;
      2'b10: src_ok = two;
      default: src_ok = 1'b0;
    endcase
  endfunction : src_ok

  function automatic logic line_ok(input logic [9:0] ln, input logic f2, input logic video_625_line_standard);
    logic [9:0] lo;
    logic [9:0] hi;
    lo = (video_625_line_standard && f2) ? 10'h13A : 10'h001;
    hi = video_625_line_standard ? (f2 ? 10'h271 : 10'h139) : (f2 ? 10'h106 : 10'h107);
    line_ok = (ln >= lo) && (ln <= hi);
  endfunction : line_ok

  // ----------------------------------------
  // AXI4-Lite write
  // ----------------------------------------
  logic aw_reg, w_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic wr_go;
  logic wr_err;
  assign s_axi_awready = !aw_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_reg && !s_axi_bvalid;
  assign wr_go = aw_reg && w_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
      end else if (wr_go) begin
        w_reg <= 1'b0;
      end
    end
  end

  // Illegal values are refused whole with SLVERR, keeping the old setting
  always_comb begin
    case (awaddr_reg)
      `DVTRG_OFF_MODE: wr_err = 1'b0;
      `DVTRG_OFF_DSRC: wr_err = !src_ok(wdata_reg[1:0], wdata_reg[7:4], twoch_s, hasdig_s) ||
                                !src_ok(wdata_reg[17:16], wdata_reg[23:20], twoch_s, hasdig_s);
      `DVTRG_OFF_DELAY: wr_err = (wdata_reg < 32'(`DVTRG_DELAY_MIN_CYC)) || (wdata_reg > DELAY_MAX_CYC);
      `DVTRG_OFF_VCFG: wr_err = wdata_reg[2:0] > 3'h3;
      `DVTRG_OFF_VLINE: wr_err = !line_ok(wdata_reg[9:0], vcfg_reg[`DVTRG_VFIELD_BIT],
                                          mode_reg == dvtrg_pkg::DVTRG_MODE_VIDEO_625);
      `DVTRG_OFF_HOLD: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_err ? 2'b10 : 2'b00;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Strobes ignored: every register is written as a whole word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= dvtrg_pkg::DVTRG_MODE_OFF;
      dsrc_reg <= 32'h0000_0010;
      delay_reg <= `DVTRG_DELAY_RST;
      vcfg_reg <= 6'h00;
      vline_reg <= 10'h001;
      hold_reg <= `DVTRG_HOLD_RST;
      reject_reg <= 1'b0;
    end else if (wr_go && !wr_err) begin
      case (awaddr_reg)
        `DVTRG_OFF_MODE: mode_reg <= dvtrg_pkg::dvtrg_mode_t'(wdata_reg[1:0]);
        `DVTRG_OFF_DSRC: dsrc_reg <= wdata_reg & 32'h01F3_01F3;
        `DVTRG_OFF_DELAY: delay_reg <= wdata_reg;
        `DVTRG_OFF_VCFG: vcfg_reg <= wdata_reg[5:0];
        `DVTRG_OFF_VLINE: vline_reg <= wdata_reg[9:0];
        `DVTRG_OFF_HOLD: begin
          hold_reg <= {1'b0, wdata_reg[30:0]};
          reject_reg <= wdata_reg[31];
        end
        default: mode_reg <= mode_reg;
      endcase
    end
  end

  // ----------------------------------------
  // AXI4-Lite read
  // ----------------------------------------
  logic fired_reg;
  dvtrg_pkg::dvtrg_state_t state_reg;
  logic [31:0] rd_mux;
  assign s_axi_arready = !s_axi_rvalid;
  always_comb begin
    case (s_axi_araddr)
      `DVTRG_OFF_MODE: rd_mux = {30'h0, mode_reg};
      `DVTRG_OFF_DSRC: rd_mux = dsrc_reg;
      `DVTRG_OFF_DELAY: rd_mux = delay_reg;
      `DVTRG_OFF_VCFG: rd_mux = {26'h0, vcfg_reg};
      `DVTRG_OFF_VLINE: rd_mux = {22'h0, vline_reg};
      `DVTRG_OFF_HOLD: rd_mux = {reject_reg, hold_reg[30:0]};
      `DVTRG_OFF_STATUS: rd_mux = {27'h0, fired_reg, twoch_s, hasdig_s, state_reg};
      `DVTRG_OFF_VARIANT: rd_mux = VARIANT_ID;
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= (s_axi_araddr[11:2] > 10'h007 || s_axi_araddr[1:0] != 2'b00) ? 2'b10 : 2'b00;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Delay-by-time sequencer
  // ----------------------------------------
  logic arm_edge, trig_edge;
  dvtrg_edge #(.NUM_ANALOG(4), .NUM_DIGITAL(NUM_DIGITAL)) u_arm (
    .aclk(aclk),
    .aresetn(aresetn),
    .analog_in(an_s),
    .digital_in(dig_s),
    .external_in(ext_s),
    .kind(dsrc_reg[17:16]),
    .index(dsrc_reg[17:16] == 2'b00 ? dsrc_reg[23:20] - 4'h1 : dsrc_reg[23:20]),
    .rising(dsrc_reg[`DVTRG_ARM_SLOPE_BIT]),
    .edge_seen(arm_edge)
  );
  dvtrg_edge #(.NUM_ANALOG(4), .NUM_DIGITAL(NUM_DIGITAL)) u_trig (
    .aclk(aclk),
    .aresetn(aresetn),
    .analog_in(an_s),
    .digital_in(dig_s),
    .external_in(ext_s),
    .kind(dsrc_reg[1:0]),
    .index(dsrc_reg[1:0] == 2'b00 ? dsrc_reg[7:4] - 4'h1 : dsrc_reg[7:4]),
    .rising(dsrc_reg[`DVTRG_SLOPE_BIT]),
    .edge_seen(trig_edge)
  );

  logic [31:0] dcount_reg;
  logic dly_fire;
  logic delay_by_time_mode_on;
  assign delay_by_time_mode_on = mode_reg == dvtrg_pkg::DVTRG_MODE_DELAY_BY_TIME;
  assign dly_fire = delay_by_time_mode_on && state_reg == dvtrg_pkg::DVTRG_ST_LOOK && trig_edge;
  always_ff @(posedge aclk) begin
    if (!aresetn || !delay_by_time_mode_on) begin
      state_reg <= dvtrg_pkg::DVTRG_ST_IDLE;
      dcount_reg <= 32'h0000_0000;
    end else begin
      case (state_reg)
        dvtrg_pkg::DVTRG_ST_IDLE: state_reg <= dvtrg_pkg::DVTRG_ST_ARMED;
        dvtrg_pkg::DVTRG_ST_ARMED: begin
          if (arm_edge) begin
            dcount_reg <= delay_reg;
            state_reg <= dvtrg_pkg::DVTRG_ST_DELAY;
          end
        end
        dvtrg_pkg::DVTRG_ST_DELAY: begin
          dcount_reg <= dcount_reg - 32'h0000_0001;
          if (dcount_reg <= 32'h0000_0001) begin
            state_reg <= dvtrg_pkg::DVTRG_ST_LOOK;
          end
        end
        dvtrg_pkg::DVTRG_ST_LOOK: begin
          if (trig_edge) begin
            state_reg <= dvtrg_pkg::DVTRG_ST_ARMED;
          end
        end
        default: state_reg <= dvtrg_pkg::DVTRG_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Standard video trigger
  // ----------------------------------------
  logic vid_on;
  logic vsel, hsel, vs_prev_reg, hs_prev_reg, vs_rise, hs_rise;
  logic [9:0] lcount_reg;
  logic vid_fire;
  logic [7:0] rej_reg;
  logic vid_cmp;
  assign vid_on = mode_reg == dvtrg_pkg::DVTRG_MODE_VIDEO_525 || mode_reg == dvtrg_pkg::DVTRG_MODE_VIDEO_625;
  assign vid_cmp = an_s[vcfg_reg[1:0]];
  // Sync pulses arrive active high from the separator; polarity flips them
  assign vsel = vs_s ^ vcfg_reg[`DVTRG_VPOL_BIT];
  assign hsel = hs_s ^ vcfg_reg[`DVTRG_VPOL_BIT];
  assign vs_rise = vsel && !vs_prev_reg;
  assign hs_rise = hsel && !hs_prev_reg;
  // Noise rejection needs the channel stable for eight cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rej_reg <= 8'h00;
      vs_prev_reg <= 1'b0;
      hs_prev_reg <= 1'b0;
      lcount_reg <= 10'h000;
    end else begin
      rej_reg <= {rej_reg[6:0], vid_cmp};
      vs_prev_reg <= vsel;
      hs_prev_reg <= hsel;
      if (vs_rise) begin
        lcount_reg <= (vcfg_reg[`DVTRG_VFIELD_BIT] && mode_reg == dvtrg_pkg::DVTRG_MODE_VIDEO_625) ?
                      10'h139 : 10'h000;
      end else if (hs_rise) begin
        lcount_reg <= lcount_reg + 10'h001;
      end
    end
  end
  assign vid_fire = vid_on && hs_rise && (lcount_reg + 10'h001 == vline_reg) &&
                    (fo_s != vcfg_reg[`DVTRG_VFIELD_BIT]) &&
                    (!reject_reg || rej_reg == 8'hFF || rej_reg == 8'h00);

  // ----------------------------------------
  // Hold-off and output
  // ----------------------------------------
  logic [31:0] hold_cnt_reg;
  logic any_fire;
  assign any_fire = (dly_fire || vid_fire) && hold_cnt_reg == 32'h0000_0000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_cnt_reg <= 32'h0000_0000;
      trigger_out <= 1'b0;
      fired_reg <= 1'b0;
    end else begin
      trigger_out <= any_fire;
      if (any_fire) begin
        hold_cnt_reg <= hold_reg;
        fired_reg <= 1'b1;
      end else if (hold_cnt_reg != 32'h0000_0000) begin
        hold_cnt_reg <= hold_cnt_reg - 32'h0000_0001;
      end
    end
  end
endmodule : dvtrg_top
`default_nettype wire

// ---- sim/dvtrg_chk.sv ----
// Checker for bus answers and the trigger pulse of dvtrg_top
// Assumes it is bound to dvtrg_top and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module dvtrg_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Trigger
  input wire logic trigger_out
);
  logic aw_got_reg;
  logic w_got_reg;
  logic ar_got_reg;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Handshake memory; a new request wins over the old answer
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) aw_got_reg <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready) aw_got_reg <= 1'b1;
    else if (s_axi_bvalid && s_axi_bready) aw_got_reg <= 1'b0;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) w_got_reg <= 1'b0;
    else if (s_axi_wvalid && s_axi_wready) w_got_reg <= 1'b1;
    else if (s_axi_bvalid && s_axi_bready) w_got_reg <= 1'b0;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) ar_got_reg <= 1'b0;
    else if (s_axi_arvalid && s_axi_arready) ar_got_reg <= 1'b1;
    else if (s_axi_rvalid && s_axi_rready) ar_got_reg <= 1'b0;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  b_stands_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  r_stands_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  b_cause_a: assert property (s_axi_bvalid |-> aw_got_reg && w_got_reg)
    else $error("write answer without request");
  b_answer_a: assert property (aw_got_reg && w_got_reg |-> ##[0:2] s_axi_bvalid)
    else $error("write answer late");
  r_cause_a: assert property (s_axi_rvalid |-> ar_got_reg)
    else $error("read answer without request");
  resp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10})
    else $error("bad write response");
  rd_err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0000_0000)
    else $error("refused read carries data");
  trig_pulse_a: assert property (trigger_out |=> !trigger_out)
    else $error("trigger longer than one cycle");
  reset_quiet_a: assert property ($rose(aresetn) |-> !trigger_out && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs busy after reset");
endmodule : dvtrg_chk
bind dvtrg_top dvtrg_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .trigger_out(trigger_out));
`default_nettype wire

// ---- sim/dvtrg_chan_model.sv ----
// Far side: channel comparator levels and a free running video sync
// Assumes the bench calls set_analog just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module dvtrg_chan_model (
  // Clock
  input wire logic aclk,
  // Channels
  output logic [3:0] analog_cmp,
  output logic [15:0] digital_in,
  output logic external_cmp,
  // Video sync
  output logic vsync_in,
  output logic hsync_in,
  output logic field_odd_in
);
  logic [3:0] pix_reg = 4'h0;
  logic [4:0] line_reg = 5'h00;
  initial begin
    analog_cmp = 4'h0;
    digital_in = 16'hA5C3;
    external_cmp = 1'b0;
    field_odd_in = 1'b1;
  end
  task automatic set_analog(input int i, input logic v);
    analog_cmp[i] <= v;
  endtask : set_analog
  // Short lines keep a frame cheap; only the sync shape matters here
  always @(posedge aclk) begin
    pix_reg <= pix_reg + 4'h1;
    if (pix_reg == 4'hF) line_reg <= (line_reg == 5'h13) ? 5'h00 : line_reg + 5'h01;
    if (pix_reg == 4'hF && line_reg == 5'h13) field_odd_in <= ~field_odd_in;
  end
  assign hsync_in = (pix_reg < 4'h2);
  assign vsync_in = (line_reg == 5'h00);
endmodule : dvtrg_chan_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// Bench for dvtrg_top: register rules and delayed triggering
// Assumes the design, the checker and the channel model compile first
`timescale 1ns/10ps
`default_nettype none
`include "dvtrg_regs.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
  $display("mismatch at %0t: got %h exp %h", $time, (a), (e)); end end
module tb_top;
  localparam logic [31:0] DMAX = 32'h0000_03E8;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam int DLY = 8;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awa = 12'h000;
  logic awv = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic wv = 1'b0;
  logic brdy = 1'b0;
  logic [11:0] ara = 12'h000;
  logic arv = 1'b0;
  logic rrdy = 1'b0;
  logic two_ch = 1'b0;
  logic has_dig = 1'b1;
  wire logic awr, wr, bv, arr, rv, trig, ext, vs, hs, fo;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rd;
  wire logic [3:0] ana;
  wire logic [15:0] dig;
  int err_count = 0;
  int check_count = 0;
  int trig_cnt = 0;
  // Source table: {two_channel, has_digital, response, value}
  logic [35:0] stbl [7] = '{{2'b01, 2'b00, 32'h0010_0040}, {2'b01, 2'b10, 32'h0010_0000},
    {2'b11, 2'b10, 32'h0010_0030}, {2'b01, 2'b10, 32'h0010_0002}, {2'b11, 2'b00, 32'h0010_0002},
    {2'b01, 2'b00, 32'h0010_01F1}, {2'b00, 2'b10, 32'h0010_01F1}};
  // Video table: {mode, config, line, response}
  logic [21:0] vtbl [8] = '{{2'b10, 8'h00, 10'h107, 2'b00}, {2'b10, 8'h00, 10'h108, 2'b10},
    {2'b10, 8'h20, 10'h106, 2'b00}, {2'b10, 8'h20, 10'h107, 2'b10}, {2'b11, 8'h20, 10'h139, 2'b10},
    {2'b11, 8'h20, 10'h13A, 2'b00}, {2'b11, 8'h11, 10'h139, 2'b00}, {2'b11, 8'h11, 10'h13A, 2'b10}};
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) if (trig === 1'b1) trig_cnt <= trig_cnt + 1;
  // Byte strobes are ignored by the block, so they stay tied
  dvtrg_top #(.NUM_DIGITAL(16), .DELAY_MAX_CYC(DMAX), .VARIANT_ID(32'h0000_0000)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .two_channel(two_ch),
    .has_digital(has_dig), .analog_cmp(ana), .digital_in(dig), .external_cmp(ext), .vsync_in(vs),
    .hsync_in(hs), .field_odd_in(fo), .trigger_out(trig));
  dvtrg_chan_model u_chan (.aclk(aclk), .analog_cmp(ana), .digital_in(dig), .external_cmp(ext),
    .vsync_in(vs), .hsync_in(hs), .field_odd_in(fo));
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge aclk);
  endtask : step
  task automatic guard(input int n);
    if (n >= 40) begin
      err_count++;
      finish_test();
    end
  endtask : guard
  // Ready is raised late on purpose so the answer has to stand
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (brdy && bv) break;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (n == 2) brdy <= 1'b1;
    end
    brdy <= 1'b0;
    `CHK(bresp, er)
    guard(n);
    @(posedge aclk);
  endtask : wr_reg
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] ed, input logic [1:0] er);
    int n;
    ara <= a;
    arv <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (rrdy && rv) break;
      if (arv && arr) arv <= 1'b0;
      if (n == 2) rrdy <= 1'b1;
    end
    rrdy <= 1'b0;
    `CHK(rd & m, ed)
    `CHK(rresp, er)
    guard(n);
    @(posedge aclk);
  endtask : rd_chk
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd_chk(`DVTRG_OFF_DSRC, ALL, 32'h0000_0010, 2'b00);
    rd_chk(`DVTRG_OFF_DELAY, ALL, 32'h0000_0001, 2'b00);
    rd_chk(`DVTRG_OFF_VLINE, ALL, 32'h0000_0001, 2'b00);
    rd_chk(`DVTRG_OFF_HOLD, ALL, 32'h0000_0000, 2'b00);
    rd_chk(`DVTRG_OFF_STATUS, 32'h0000_000C, 32'h0000_0004, 2'b00);
    rd_chk(12'h100, ALL, 32'h0000_0000, 2'b10);
    wr_reg(12'h100, 32'h0000_0001, 2'b10);
  endtask : t_reset
  task automatic t_range();
    wr_reg(`DVTRG_OFF_DELAY, 32'h0000_0000, 2'b10);
    wr_reg(`DVTRG_OFF_DELAY, DMAX + 32'h0000_0001, 2'b10);
    rd_chk(`DVTRG_OFF_DELAY, ALL, 32'h0000_0001, 2'b00);
    wr_reg(`DVTRG_OFF_DELAY, DMAX, 2'b00);
    rd_chk(`DVTRG_OFF_DELAY, ALL, DMAX, 2'b00);
  endtask : t_range
  task automatic t_src();
    logic [31:0] last;
    last = 32'h0000_0010;
    for (int i = 0; i < 7; i++) begin
      two_ch <= stbl[i][35];
      has_dig <= stbl[i][34];
      step(4);
      wr_reg(`DVTRG_OFF_DSRC, stbl[i][31:0], stbl[i][33:32]);
      if (stbl[i][33:32] == 2'b00) last = stbl[i][31:0];
      rd_chk(`DVTRG_OFF_DSRC, ALL, last, 2'b00);
    end
    rd_chk(`DVTRG_OFF_STATUS, 32'h0000_000C, 32'h0000_0000, 2'b00);
    two_ch <= 1'b0;
    has_dig <= 1'b1;
    step(4);
  endtask : t_src
  task automatic t_fire(input logic s);
    int c0;
    wr_reg(`DVTRG_OFF_MODE, 32'h0000_0000, 2'b00);
    wr_reg(`DVTRG_OFF_DELAY, 32'(DLY), 2'b00);
    wr_reg(`DVTRG_OFF_DSRC, 32'h0110_0020 | {23'h00_0000, s, 8'h00}, 2'b00);
    u_chan.set_analog(0, 1'b0);
    u_chan.set_analog(1, s);
    step(4);
    wr_reg(`DVTRG_OFF_MODE, 32'h0000_0001, 2'b00);
    step(2);
    c0 = trig_cnt;
    u_chan.set_analog(0, 1'b1);
    step(2);
    u_chan.set_analog(1, ~s);
    step(1);
    u_chan.set_analog(1, s);
    step(6);
    `CHK(trig_cnt, c0)
    step(DLY + 4);
    u_chan.set_analog(1, ~s);
    step(6);
    `CHK(trig_cnt, c0)
    u_chan.set_analog(1, s);
    step(6);
    `CHK(trig_cnt, c0 + 1)
    rd_chk(`DVTRG_OFF_STATUS, 32'h0000_0010, 32'h0000_0010, 2'b00);
  endtask : t_fire
  task automatic t_video();
    logic [31:0] last;
    int c0;
    last = 32'h0000_0001;
    for (int i = 0; i < 8; i++) begin
      wr_reg(`DVTRG_OFF_MODE, {30'h0000_0000, vtbl[i][21:20]}, 2'b00);
      wr_reg(`DVTRG_OFF_VCFG, {24'h00_0000, vtbl[i][19:12]}, 2'b00);
      rd_chk(`DVTRG_OFF_VCFG, 32'h0000_0033, {24'h00_0000, vtbl[i][19:12]}, 2'b00);
      wr_reg(`DVTRG_OFF_VLINE, {22'h00_0000, vtbl[i][11:2]}, vtbl[i][1:0]);
      if (vtbl[i][1:0] == 2'b00) last = {22'h00_0000, vtbl[i][11:2]};
      rd_chk(`DVTRG_OFF_VLINE, ALL, last, 2'b00);
    end
    wr_reg(`DVTRG_OFF_HOLD, 32'h8000_0010, 2'b00);
    rd_chk(`DVTRG_OFF_HOLD, ALL, 32'h8000_0010, 2'b00);
    // Same polarity as before, so the line count stays in step with the model
    wr_reg(`DVTRG_OFF_MODE, 32'h0000_0002, 2'b00);
    wr_reg(`DVTRG_OFF_VCFG, 32'h0000_0010, 2'b00);
    wr_reg(`DVTRG_OFF_VLINE, 32'h0000_0003, 2'b00);
    c0 = trig_cnt;
    // One model frame is two fields of 20 lines of 16 cycles
    step(640);
    `CHK(trig_cnt, c0 + 1)
  endtask : t_video
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  initial begin
    step(3);
    aresetn <= 1'b1;
    step(1);
    t_reset();
    t_range();
    t_src();
    t_fire(1'b1);
    t_fire(1'b0);
    t_video();
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
